/* File: inc/usl_pkg.sv */
// Purpose: Shared constants and carriers for the UART sleep, loopback and register block.
// Assumes: Two channels, 8-bit registers, 3-bit host address.
// Notes: Offsets are register indices on the host address lines.
package usl_pkg;
  // Offsets in the normal register set.
  localparam logic [2:0] OFS_HOLD = 3'h0;
  localparam logic [2:0] OFS_IEN = 3'h1;
  localparam logic [2:0] OFS_ISTAT = 3'h2;
  localparam logic [2:0] OFS_LCTL = 3'h3;
  localparam logic [2:0] OFS_MCTL = 3'h4;
  localparam logic [2:0] OFS_LSTAT = 3'h5;
  localparam logic [2:0] OFS_MSTAT = 3'h6;
  localparam logic [2:0] OFS_SCR = 3'h7;
  // Offset of the first flow character in the enhanced set.
  localparam logic [2:0] OFS_CHAR0 = 3'h4;
  // Bit positions.
  localparam int IEN_SLEEP_BIT = 4;
  localparam int LCTL_DIV_BIT = 7;
  localparam int MCTL_DTR_BIT = 0;
  localparam int MCTL_RTS_BIT = 1;
  localparam int MCTL_OP1_BIT = 2;
  localparam int MCTL_OP2_BIT = 3;
  localparam int MCTL_LOOP_BIT = 4;
  localparam int EFN_UNLOCK_BIT = 4;
  localparam int EFN_ARTS_BIT = 6;
  localparam int EFN_ACTS_BIT = 7;
  localparam int IST_NOPEND_BIT = 0;
  // Key value of line control that opens the enhanced set.
  localparam logic [7:0] LCTL_ENH_KEY = 8'hbf;
  // Reset value of every writable register.
  localparam logic [7:0] REG_RST = 8'h00;
  // Divisor byte value that exposes revision and identity.
  localparam logic [7:0] DIV_ZERO = 8'h00;
  // Interrupt enable bits writable without the unlock bit.
  localparam logic [7:0] IEN_LOW_MASK = 8'h0f;
  // Modem inputs in modem status bit order, cd highest.
  typedef struct packed {
    logic cd;
    logic ri;
    logic dsr;
    logic cts;
  } usl_modem_t;
  // State handed in by the rest of one channel.
  typedef struct packed {
    logic [7:0] rx_data;
    logic [7:0] irq_status;
    logic [7:0] line_status;
    logic tx_shift;
  } usl_core_in_t;
  // Strobes and paths handed to the rest of one channel.
  typedef struct packed {
    logic tx_load;
    logic queue_load;
    logic rx_read;
    logic rx_shift_in;
    logic auto_rts_on;
    logic auto_cts_on;
  } usl_core_out_t;
  // Power state of the device.
  typedef enum logic [0:0] {
    USL_AWAKE = 1'b0,
    USL_ASLEEP = 1'b1
  } usl_pwr_t;
endpackage

/* File: hw/usl_power_regmap.sv */
// Purpose: Sleep, auto wake, bus isolation, loopback and banked register decode, two channels.
// Assumes: Host strobes and serial pins are synchronous to clock.
// Notes: Strobes act on their falling edge; read data is held until the next read.
// Functional notes
// - Sleep only with no interrupt pending anywhere.
// - Sleep only with non-zero baud divisor.
// - Sleep only with sleep enable in both.
// - Sleep needs clear modem deltas, idle receive.
// - Oscillator output stops while asleep.
// - Wake on start bit, transmit write, modem.
// - Auto return to sleep once interrupts cleared.
// - Modem status read clears modem change bits.
// - Cycle sleep until sleep enable is cleared.
// - Isolate bus when select high and asleep.
// - Isolation blocks address, data and strobes.
// - Isolated wake only on start bit, modem.
// - Re-isolate after modem read and service.
// - Isolation ends with enable clear or pin.
// - Modem control bit 4 enables loopback.
// - Loopback feeds transmit into receive shift.
// - Loopback holds pins idle, ignores modem inputs.
// - No auto flow control during loopback.
// - Address picks register, select picks channel.
// - Divisor at 0,1 with bit7, not key.
// - Revision, identity replace zero divisor bytes.
// - Key value maps enhanced and flow characters.
// - Upper enable bits need unlock bit set.
module usl_power_regmap #(
  // Revision code; value is arbitrary.
  parameter logic [7:0] CHIP_REV = 8'h11,
  // Identity code; value is arbitrary.
  parameter logic [7:0] CHIP_ID = 8'h5a
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [2:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic chan_a_select_n,
  input wire logic chan_b_select_n,
  input wire logic host_write_n,
  input wire logic host_read_n,
  output logic [7:0] host_rdata,
  input wire logic bus_isolate_select,
  input wire logic [1:0] rx_pin,
  output logic [1:0] tx_pin,
  input wire usl_pkg::usl_modem_t [1:0] modem_in_n,
  output logic [1:0] rts_n,
  output logic [1:0] dtr_n,
  input wire usl_pkg::usl_core_in_t [1:0] core_in,
  output usl_pkg::usl_core_out_t [1:0] core_out,
  output logic osc_output_pin,
  output logic asleep,
  output logic isolated
);

  // True when divisor bytes own offsets 0 and 1.
  function automatic logic div_access(input logic [7:0] lctl);
    div_access = lctl[usl_pkg::LCTL_DIV_BIT] && (lctl != usl_pkg::LCTL_ENH_KEY);
  endfunction

  // True when the enhanced set owns offsets 2 and 4 to 7.
  function automatic logic enh_access(input logic [7:0] lctl);
    enh_access = (lctl == usl_pkg::LCTL_ENH_KEY);
  endfunction

  // Per-channel control registers.
  logic [7:0] ien_reg [2];
  logic [7:0] lctl_reg [2];
  logic [7:0] mctl_reg [2];
  logic [7:0] div_lo_reg [2];
  logic [7:0] div_hi_reg [2];
  logic [7:0] efn_reg [2];
  logic [7:0] scr_reg [2];
  // Flow characters: resume one, resume two, halt one, halt two.
  logic [7:0] char_reg [2][4];
  // Sticky modem change bits per channel.
  logic [3:0] delta_reg [2];
  // Previous modem levels, for change detection.
  usl_pkg::usl_modem_t [1:0] modem_prev_reg;
  // Previous receive pin levels, for start bit detection.
  logic [1:0] rx_prev_reg;
  // Previous effective strobe levels.
  logic wr_prev_reg;
  logic rd_prev_reg;
  // Power state and its next value.
  usl_pkg::usl_pwr_t pwr_reg;
  usl_pkg::usl_pwr_t pwr_next;
  // Output flops.
  logic [7:0] rdata_reg;
  logic [1:0] tx_pin_reg;
  logic [1:0] rts_n_reg;
  logic [1:0] dtr_n_reg;
  usl_pkg::usl_core_out_t [1:0] core_out_reg;
  logic osc_reg;
  logic iso_reg;

  // Effective host signals after isolation.
  logic wr_n_eff;
  logic rd_n_eff;
  logic sel_a;
  logic sel_b;
  logic wr_take;
  logic rd_take;
  logic chan;
  logic [1:0] hit_wr;
  logic [1:0] hit_rd;
  // Modem levels seen by each channel, active high.
  usl_pkg::usl_modem_t [1:0] modem_act;
  logic [1:0] loop_on;
  logic [3:0] modem_chg [2];
  logic [1:0] rx_fall;
  logic [1:0] tx_write;
  logic can_sleep;
  logic wake_any;
  logic [7:0] rd_value;

  // Host bus gating and strobe edge detection.
  always_comb
  begin
    wr_n_eff = iso_reg | host_write_n;
    rd_n_eff = iso_reg | host_read_n;
    sel_a = ~iso_reg & ~chan_a_select_n;
    sel_b = ~iso_reg & ~chan_b_select_n;
    wr_take = wr_prev_reg & ~wr_n_eff;
    rd_take = rd_prev_reg & ~rd_n_eff;
    chan = ~sel_a & sel_b;
    hit_wr = '0;
    hit_rd = '0;
    hit_wr[chan] = wr_take & (sel_a | sel_b);
    hit_rd[chan] = rd_take & (sel_a | sel_b);
  end

  // Modem levels, change detection and wake sources per channel.
  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      loop_on[c] = mctl_reg[c][usl_pkg::MCTL_LOOP_BIT];
      if (loop_on[c])
      begin
        // Loopback turns the modem outputs back as inputs.
        modem_act[c].cd = mctl_reg[c][usl_pkg::MCTL_OP2_BIT];
        modem_act[c].ri = mctl_reg[c][usl_pkg::MCTL_OP1_BIT];
        modem_act[c].dsr = mctl_reg[c][usl_pkg::MCTL_DTR_BIT];
        modem_act[c].cts = mctl_reg[c][usl_pkg::MCTL_RTS_BIT];
      end
      else
      begin
        // Pins are active low.
        modem_act[c] = ~modem_in_n[c];
      end
      modem_chg[c] = modem_act[c] ^ modem_prev_reg[c];
      rx_fall[c] = rx_prev_reg[c] & ~rx_pin[c];
      // A holding write is a transmit load when divisors are hidden.
      tx_write[c] = hit_wr[c] && (host_addr == usl_pkg::OFS_HOLD)
        && !div_access(lctl_reg[c]);
    end
  end

  // Sleep entry condition and wake sources across both channels.
  always_comb
  begin
    can_sleep = 1'b1;
    wake_any = 1'b0;
    for (int c = 0; c < 2; c++)
    begin
      if (!core_in[c].irq_status[usl_pkg::IST_NOPEND_BIT])
        can_sleep = 1'b0;
      if ({div_hi_reg[c], div_lo_reg[c]} == {usl_pkg::DIV_ZERO, usl_pkg::DIV_ZERO})
        can_sleep = 1'b0;
      if (!ien_reg[c][usl_pkg::IEN_SLEEP_BIT])
        can_sleep = 1'b0;
      if (delta_reg[c] != 4'h0 || !rx_pin[c])
        can_sleep = 1'b0;
      if (rx_fall[c] || modem_chg[c] != 4'h0 || (tx_write[c] && !iso_reg))
        wake_any = 1'b1;
    end
  end

  // Next power state.
  always_comb
  begin
    pwr_next = pwr_reg;
    unique case (pwr_reg)
      usl_pkg::USL_AWAKE:
      begin
        if (can_sleep && !wake_any)
          pwr_next = usl_pkg::USL_ASLEEP;
      end
      usl_pkg::USL_ASLEEP:
      begin
        if (wake_any || !can_sleep)
          pwr_next = usl_pkg::USL_AWAKE;
      end
    endcase
  end

  // Power state, isolation and oscillator output.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      pwr_reg <= usl_pkg::USL_AWAKE;
      iso_reg <= 1'b0;
      osc_reg <= 1'b0;
    end
    else
    begin
      pwr_reg <= pwr_next;
      iso_reg <= (pwr_next == usl_pkg::USL_ASLEEP) & bus_isolate_select;
      osc_reg <= (pwr_next == usl_pkg::USL_ASLEEP) ? 1'b0 : ~osc_reg;
    end
  end

  // Strobe, receive and modem history.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      wr_prev_reg <= 1'b1;
      rd_prev_reg <= 1'b1;
      rx_prev_reg <= 2'b11;
      modem_prev_reg <= '0;
    end
    else
    begin
      wr_prev_reg <= wr_n_eff;
      rd_prev_reg <= rd_n_eff;
      rx_prev_reg <= rx_pin;
      modem_prev_reg <= modem_act;
    end
  end

  // Register writes, banked per channel.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      for (int c = 0; c < 2; c++)
      begin
        ien_reg[c] <= usl_pkg::REG_RST;
        lctl_reg[c] <= usl_pkg::REG_RST;
        mctl_reg[c] <= usl_pkg::REG_RST;
        div_lo_reg[c] <= usl_pkg::REG_RST;
        div_hi_reg[c] <= usl_pkg::REG_RST;
        efn_reg[c] <= usl_pkg::REG_RST;
        scr_reg[c] <= usl_pkg::REG_RST;
        for (int k = 0; k < 4; k++)
          char_reg[c][k] <= usl_pkg::REG_RST;
      end
    end
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        if (hit_wr[c])
        begin
          unique case (host_addr)
            usl_pkg::OFS_HOLD:
            begin
              if (div_access(lctl_reg[c]))
                div_lo_reg[c] <= host_wdata;
            end
            usl_pkg::OFS_IEN:
            begin
              if (div_access(lctl_reg[c]))
                div_hi_reg[c] <= host_wdata;
              else if (efn_reg[c][usl_pkg::EFN_UNLOCK_BIT])
                ien_reg[c] <= host_wdata;
              else
                ien_reg[c] <= (ien_reg[c] & ~usl_pkg::IEN_LOW_MASK)
                  | (host_wdata & usl_pkg::IEN_LOW_MASK);
            end
            usl_pkg::OFS_ISTAT:
            begin
              if (enh_access(lctl_reg[c]))
                efn_reg[c] <= host_wdata;
            end
            usl_pkg::OFS_LCTL:
              lctl_reg[c] <= host_wdata;
            default:
            begin
              // flow characters at 4 to 7
              if (enh_access(lctl_reg[c]))
                char_reg[c][2'(host_addr - usl_pkg::OFS_CHAR0)] <= host_wdata;
              else if (host_addr == usl_pkg::OFS_MCTL)
                mctl_reg[c] <= host_wdata;
              else if (host_addr == usl_pkg::OFS_SCR)
                scr_reg[c] <= host_wdata;
            end
          endcase
        end
      end
    end
  end

  // Sticky modem change bits; a new change wins over the read clear.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      delta_reg[0] <= 4'h0;
      delta_reg[1] <= 4'h0;
    end
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        if (hit_rd[c] && host_addr == usl_pkg::OFS_MSTAT && !enh_access(lctl_reg[c]))
          delta_reg[c] <= modem_chg[c];
        else
          delta_reg[c] <= delta_reg[c] | modem_chg[c];
      end
    end
  end

  // Read multiplexer for the selected channel.
  always_comb
  begin
    rd_value = usl_pkg::REG_RST;
    unique case (host_addr)
      usl_pkg::OFS_HOLD:
      begin
        if (!div_access(lctl_reg[chan]))
          rd_value = core_in[chan].rx_data;
        else if (div_lo_reg[chan] == usl_pkg::DIV_ZERO && div_hi_reg[chan] == usl_pkg::DIV_ZERO)
          rd_value = CHIP_REV;
        else
          rd_value = div_lo_reg[chan];
      end
      usl_pkg::OFS_IEN:
      begin
        if (!div_access(lctl_reg[chan]))
          rd_value = ien_reg[chan];
        else if (div_lo_reg[chan] == usl_pkg::DIV_ZERO && div_hi_reg[chan] == usl_pkg::DIV_ZERO)
          rd_value = CHIP_ID;
        else
          rd_value = div_hi_reg[chan];
      end
      usl_pkg::OFS_ISTAT:
        rd_value = enh_access(lctl_reg[chan]) ? efn_reg[chan] : core_in[chan].irq_status;
      usl_pkg::OFS_LCTL:
        rd_value = lctl_reg[chan];
      default:
      begin
        if (enh_access(lctl_reg[chan]))
          rd_value = char_reg[chan][2'(host_addr - usl_pkg::OFS_CHAR0)];
        else if (host_addr == usl_pkg::OFS_MCTL)
          rd_value = mctl_reg[chan];
        else if (host_addr == usl_pkg::OFS_LSTAT)
          rd_value = core_in[chan].line_status;
        else if (host_addr == usl_pkg::OFS_MSTAT)
          rd_value = {modem_act[chan], delta_reg[chan]};
        else
          rd_value = scr_reg[chan];
      end
    endcase
  end

  // Read data holds until the next read edge.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      rdata_reg <= usl_pkg::REG_RST;
    else if (hit_rd != 2'b00)
      rdata_reg <= rd_value;
  end

  // Serial pins, core paths and strobes per channel.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      tx_pin_reg <= 2'b11;
      rts_n_reg <= 2'b11;
      dtr_n_reg <= 2'b11;
      core_out_reg <= '0;
    end
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        tx_pin_reg[c] <= loop_on[c] | core_in[c].tx_shift;
        rts_n_reg[c] <= loop_on[c] | ~mctl_reg[c][usl_pkg::MCTL_RTS_BIT];
        dtr_n_reg[c] <= loop_on[c] | ~mctl_reg[c][usl_pkg::MCTL_DTR_BIT];
        core_out_reg[c].rx_shift_in <= loop_on[c] ? core_in[c].tx_shift : rx_pin[c];
        core_out_reg[c].auto_rts_on <= efn_reg[c][usl_pkg::EFN_ARTS_BIT] & ~loop_on[c];
        core_out_reg[c].auto_cts_on <= efn_reg[c][usl_pkg::EFN_ACTS_BIT] & ~loop_on[c];
        core_out_reg[c].tx_load <= tx_write[c];
        core_out_reg[c].queue_load <= hit_wr[c] && host_addr == usl_pkg::OFS_ISTAT
          && !enh_access(lctl_reg[c]);
        core_out_reg[c].rx_read <= hit_rd[c] && host_addr == usl_pkg::OFS_HOLD
          && !div_access(lctl_reg[c]);
      end
    end
  end

  // Top outputs, all from flops.
  assign host_rdata = rdata_reg;
  assign tx_pin = tx_pin_reg;
  assign rts_n = rts_n_reg;
  assign dtr_n = dtr_n_reg;
  assign core_out = core_out_reg;
  assign osc_output_pin = osc_reg;
  assign asleep = pwr_reg;
  assign isolated = iso_reg;

endmodule

/* File: verification/usl_power_regmap_sva.sv */
// Purpose: Concurrent checks on the sleep, isolation and read paths of the power block.
// Assumes: One clock domain; reset is asynchronous and active high.
// Notes: Sees only the top module ports; bound below.
module usl_power_regmap_sva (
  input wire logic clock,
  input wire logic reset,
  input wire logic host_read_n,
  input wire logic [7:0] host_rdata,
  input wire logic bus_isolate_select,
  input wire logic [1:0] rx_pin,
  input wire usl_pkg::usl_core_in_t [1:0] core_in,
  input wire usl_pkg::usl_core_out_t [1:0] core_out,
  input wire logic osc_output_pin,
  input wire logic asleep,
  input wire logic isolated
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  // The device is awake on the following edge.
  sequence s_wake;
    ##1 !asleep;
  endsequence
  // Awake and with the bus no longer isolated on the following edge.
  sequence s_full_wake;
    ##1 (!asleep && !isolated);
  endsequence
  AST_SLEEP_NOPEND: assert property ($rose(asleep) |->
    $past(core_in[0].irq_status[0] && core_in[1].irq_status[0])) else $error("sleep with irq");
  AST_SLEEP_RX_IDLE: assert property ($rose(asleep) |-> $past(rx_pin) == 2'h3)
    else $error("sleep with rx low");
  AST_OSC_STOP: assert property (asleep |-> !osc_output_pin) else $error("osc runs asleep");
  AST_PEND_WAKE: assert property ((!core_in[0].irq_status[0] || !core_in[1].irq_status[0])
    |-> s_wake) else $error("asleep with irq pending");
  AST_RX_WAKE: assert property (asleep && $fell(rx_pin[0]) |-> s_full_wake)
    else $error("start bit did not wake");
  AST_ISO_RX_WAKE: assert property (isolated && $fell(rx_pin[1]) |-> s_full_wake)
    else $error("start bit did not end isolation");
  AST_ISO_NO_LOAD: assert property (isolated |-> ##1
    !(core_out[0].tx_load || core_out[1].tx_load)) else $error("load while isolated");
  AST_ISO_ENTRY: assert property ($rose(asleep) |-> isolated == $past(bus_isolate_select))
    else $error("isolation entry wrong");
  AST_ISO_PIN_LOW: assert property (isolated && !bus_isolate_select |-> ##1 !isolated)
    else $error("isolation kept with pin low");
  AST_RDATA_HOLD: assert property ($past(host_read_n) |-> $stable(host_rdata))
    else $error("read data changed without read");
endmodule

bind usl_power_regmap usl_power_regmap_sva u_sva (.clock(clock), .reset(reset),
  .host_read_n(host_read_n), .host_rdata(host_rdata), .bus_isolate_select(bus_isolate_select),
  .rx_pin(rx_pin), .core_in(core_in), .core_out(core_out), .osc_output_pin(osc_output_pin),
  .asleep(asleep), .isolated(isolated));

/* File: verification/usl_far_model.sv */
// Purpose: Remote serial device and channel core state seen by the power block.
// Assumes: Bench sets requests at the falling edge; lines move after the rising edge.
// Notes: Transmit shift output toggles every cycle to exercise the loop path.
module usl_far_model (
  input wire logic clock,
  input wire logic reset,
  input wire logic [1:0] pend,
  input wire logic [1:0] start_req,
  input wire usl_pkg::usl_modem_t [1:0] modem_lvl,
  output logic [1:0] rx_pin,
  output usl_pkg::usl_modem_t [1:0] modem_in_n,
  output usl_pkg::usl_core_in_t [1:0] core_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Drive the lines and core state just after each rising edge.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      rx_pin <= 2'h3;
      modem_in_n <= '1;
      for (int i = 0; i < 2; i++)
        core_in[i] <= {8'h00, 8'h01, 8'h00, 1'b0};
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        // A start bit holds the line low while requested.
        rx_pin[i] <= ~start_req[i];
        modem_in_n[i] <= ~modem_lvl[i];
        // Bit 0 high means no interrupt pending.
        core_in[i].irq_status <= {7'h00, ~pend[i]};
        core_in[i].rx_data <= (i == 0) ? 8'h3c : 8'h3d;
        core_in[i].line_status <= 8'h60;
        core_in[i].tx_shift <= ~core_in[i].tx_shift;
      end
    end
  end
endmodule

/* File: verification/usl_power_regmap_tb.sv */
// Purpose: Self-checking bench for register decode, sleep, isolation and loopback.
// Assumes: Inputs change at the falling edge; a strobe is taken at one rising edge.
// Notes: Identity codes below are arbitrary.
module usl_power_regmap_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Arbitrary revision and identity values handed to the design.
  localparam logic [7:0] REV_CODE = 8'h11;
  localparam logic [7:0] ID_CODE = 8'h5a;
  logic clock, reset, host_write_n, host_read_n, chan_a_select_n, chan_b_select_n;
  logic bus_isolate_select, osc_output_pin, asleep, isolated, slp_d;
  logic [2:0] host_addr;
  logic [7:0] host_wdata, host_rdata;
  logic [1:0] rx_pin, tx_pin, rts_n, dtr_n, pend, start_req;
  usl_pkg::usl_modem_t [1:0] modem_in_n, modem_lvl;
  usl_pkg::usl_core_in_t [1:0] core_in;
  usl_pkg::usl_core_out_t [1:0] core_out;
  int error_cnt, comparisons, wake_cnt, w, rd_pulse_cnt;
  usl_power_regmap #(.CHIP_REV(REV_CODE), .CHIP_ID(ID_CODE)) uut (.clock(clock), .reset(reset),
    .host_addr(host_addr), .host_wdata(host_wdata), .chan_a_select_n(chan_a_select_n),
    .chan_b_select_n(chan_b_select_n), .host_write_n(host_write_n), .host_read_n(host_read_n),
    .host_rdata(host_rdata), .bus_isolate_select(bus_isolate_select), .rx_pin(rx_pin),
    .tx_pin(tx_pin), .modem_in_n(modem_in_n), .rts_n(rts_n), .dtr_n(dtr_n), .core_in(core_in),
    .core_out(core_out), .osc_output_pin(osc_output_pin), .asleep(asleep), .isolated(isolated));
  usl_far_model far (.clock(clock), .reset(reset), .pend(pend), .start_req(start_req),
    .modem_lvl(modem_lvl), .rx_pin(rx_pin), .modem_in_n(modem_in_n), .core_in(core_in));
  // Free-running 50 MHz clock.
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Count drops out of sleep and channel B receive reads, where values have settled.
  always @(negedge clock)
  begin
    if (slp_d === 1'b1 && asleep === 1'b0)
      wake_cnt++;
    if (core_out[1].rx_read === 1'b1)
      rd_pulse_cnt++;
    slp_d = asleep;
  end
  // Compare one value and report a mismatch at once.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // One host write; the strobe rises again before the next request.
  task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic ch);
    @(negedge clock);
    host_addr = a;
    host_wdata = d;
    chan_a_select_n = ch;
    chan_b_select_n = ~ch;
    host_write_n = 1'b0;
    @(negedge clock);
    host_write_n = 1'b1;
    chan_a_select_n = 1'b1;
    chan_b_select_n = 1'b1;
  endtask
  // One host read, judged once the data has landed.
  task automatic rd_chk(input logic [2:0] a, input logic ch, input logic [7:0] exp);
    @(negedge clock);
    host_addr = a;
    chan_a_select_n = ch;
    chan_b_select_n = ~ch;
    host_read_n = 1'b0;
    @(negedge clock);
    host_read_n = 1'b1;
    chan_a_select_n = 1'b1;
    chan_b_select_n = 1'b1;
    @(negedge clock);
    chk(host_rdata, exp, "read data");
  endtask
  // Wait, bounded, for the sleep state to reach a level.
  task automatic wait_sleep(input logic v);
    int n;
    n = 0;
    while (asleep !== v && n < 30)
    begin
      @(negedge clock);
      n++;
    end
    chk({7'h00, asleep}, {7'h00, v}, "sleep state");
  endtask
  // Open the divisor, unlock upper enables and enable sleep on one channel.
  task automatic prep(input logic ch);
    wr(3'h3, 8'h80, ch);
    wr(3'h0, 8'h01, ch);
    wr(3'h3, 8'hbf, ch);
    wr(3'h2, 8'h10, ch);
    wr(3'h3, 8'h03, ch);
    wr(3'h1, 8'h10, ch);
  endtask
  // Banked decode, channel select and guarded enable bits.
  task automatic t_decode;
    wr(3'h7, 8'h5a, 1'b0);
    wr(3'h7, 8'hc3, 1'b1);
    wr(3'h2, 8'h01, 1'b1);
    chk({7'h00, core_out[1].queue_load}, 8'h01, "queue load");
    rd_chk(3'h7, 1'b0, 8'h5a);
    rd_chk(3'h7, 1'b1, 8'hc3);
    rd_chk(3'h0, 1'b1, 8'h3d);
    chk(8'(rd_pulse_cnt), 8'h01, "receive read");
    wr(3'h3, 8'h80, 1'b0);
    rd_chk(3'h0, 1'b0, REV_CODE);
    rd_chk(3'h1, 1'b0, ID_CODE);
    wr(3'h0, 8'h01, 1'b0);
    rd_chk(3'h0, 1'b0, 8'h01);
    rd_chk(3'h1, 1'b0, 8'h00);
    wr(3'h3, 8'h03, 1'b0);
    wr(3'h1, 8'hff, 1'b0);
    rd_chk(3'h1, 1'b0, 8'h0f);
    wr(3'h3, 8'hbf, 1'b0);
    wr(3'h4, 8'h77, 1'b0);
    wr(3'h2, 8'h10, 1'b0);
    rd_chk(3'h4, 1'b0, 8'h77);
    rd_chk(3'h2, 1'b0, 8'h10);
    wr(3'h3, 8'h03, 1'b0);
    rd_chk(3'h4, 1'b0, 8'h00);
    wr(3'h1, 8'hff, 1'b0);
    rd_chk(3'h1, 1'b0, 8'hff);
    wr(3'h1, 8'h00, 1'b0);
    $display("test decode done");
  endtask
  // Sleep entry, each wake source and automatic return.
  task automatic t_sleep;
    prep(1'b0);
    prep(1'b1);
    wait_sleep(1'b1);
    chk({7'h00, osc_output_pin}, 8'h00, "oscillator");
    pend = 2'b10;
    wait_sleep(1'b0);
    pend = 2'b00;
    wait_sleep(1'b1);
    start_req = 2'b01;
    wait_sleep(1'b0);
    repeat (6) @(negedge clock);
    chk({7'h00, asleep}, 8'h00, "rx low blocks sleep");
    start_req = 2'b00;
    wait_sleep(1'b1);
    w = wake_cnt;
    wr(3'h0, 8'h55, 1'b0);
    chk({7'h00, core_out[0].tx_load}, 8'h01, "transmit load");
    repeat (4) @(negedge clock);
    chk(8'(wake_cnt - w), 8'h01, "write wake");
    modem_lvl[0].cts = 1'b1;
    wait_sleep(1'b0);
    repeat (6) @(negedge clock);
    chk({7'h00, asleep}, 8'h00, "delta blocks sleep");
    rd_chk(3'h6, 1'b0, 8'h11);
    wait_sleep(1'b1);
    wr(3'h1, 8'h00, 1'b0);
    repeat (10) @(negedge clock);
    chk({7'h00, asleep}, 8'h00, "sleep disabled");
    w = osc_output_pin;
    @(negedge clock);
    chk({7'h00, osc_output_pin}, {7'h00, ~w[0]}, "oscillator runs");
    wr(3'h1, 8'h10, 1'b0);
    wait_sleep(1'b1);
    $display("test sleep done");
  endtask
  // Bus isolation entry, blocked bus, wake sources and exit.
  task automatic t_iso;
    bus_isolate_select = 1'b1;
    pend = 2'b01;
    wait_sleep(1'b0);
    pend = 2'b00;
    wait_sleep(1'b1);
    chk({7'h00, isolated}, 8'h01, "isolated");
    w = wake_cnt;
    wr(3'h0, 8'h66, 1'b0);
    chk({7'h00, core_out[0].tx_load}, 8'h00, "isolated load");
    wr(3'h7, 8'hee, 1'b0);
    repeat (4) @(negedge clock);
    chk(8'(wake_cnt - w), 8'h00, "isolated write");
    start_req = 2'b10;
    wait_sleep(1'b0);
    chk({7'h00, isolated}, 8'h00, "isolation left");
    start_req = 2'b00;
    wait_sleep(1'b1);
    modem_lvl[0].dsr = 1'b1;
    wait_sleep(1'b0);
    rd_chk(3'h6, 1'b0, 8'h32);
    wait_sleep(1'b1);
    chk({7'h00, isolated}, 8'h01, "isolated again");
    bus_isolate_select = 1'b0;
    repeat (3) @(negedge clock);
    chk({7'h00, isolated}, 8'h00, "select low");
    rd_chk(3'h7, 1'b0, 8'h5a);
    wr(3'h1, 8'h00, 1'b0);
    wr(3'h1, 8'h00, 1'b1);
    wait_sleep(1'b0);
    $display("test isolation done");
  endtask
  // Internal loopback on channel A with auto flow enabled.
  task automatic t_loop;
    wr(3'h3, 8'hbf, 1'b0);
    wr(3'h2, 8'hd0, 1'b0);
    wr(3'h3, 8'h03, 1'b0);
    wr(3'h4, 8'h13, 1'b0);
    @(negedge clock);
    chk({5'h00, tx_pin[0], rts_n[0], dtr_n[0]}, 8'h07, "loop pins");
    chk({6'h00, core_out[0].auto_rts_on, core_out[0].auto_cts_on}, 8'h00, "auto");
    repeat (3)
    begin
      @(negedge clock);
      chk({7'h00, core_out[0].rx_shift_in}, {7'h00, ~core_in[0].tx_shift}, "loop");
    end
    modem_lvl[0].ri = 1'b1;
    repeat (3) @(negedge clock);
    rd_chk(3'h6, 1'b0, 8'h30);
    wr(3'h4, 8'h03, 1'b0);
    @(negedge clock);
    chk({5'h00, tx_pin[0], rts_n[0], dtr_n[0]}, {5'h00, ~core_in[0].tx_shift, 2'h0}, "pins");
    chk({6'h00, core_out[0].auto_rts_on, core_out[0].auto_cts_on}, 8'h03, "auto on");
    $display("test loopback done");
  endtask
  // Print the counts and the verdict, then stop.
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Watchdog well beyond the few hundred cycles the tests need.
  initial
  begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    $display("BAD %0t watchdog expired", $time);
    test_done;
  end
  // Main sequence.
  initial
  begin
    {host_write_n, host_read_n, chan_a_select_n, chan_b_select_n} = 4'hf;
    {host_addr, host_wdata, bus_isolate_select, pend, start_req} = '0;
    modem_lvl = '0;
    reset = 1'b1;
    repeat (2) @(negedge clock);
    reset = 1'b0;
    repeat (2) @(negedge clock);
    t_decode;
    t_sleep;
    t_iso;
    t_loop;
    test_done;
  end
endmodule
